// ### ptpps_cfg.svh
`ifndef PTPPS_CFG_SVH
`define PTPPS_CFG_SVH

// register indices; byte address is four times the index
`define PTPPS_IDX_FLAG    10'h00c
`define PTPPS_IDX_COUNT   10'h011
`define PTPPS_IDX_CTRL    10'h012
`define PTPPS_IDX_PERIOD  10'h092
`define PTPPS_AW          12
`define PTPPS_BYTE_LANE   2'h0

// reset values
`define PTPPS_COUNT_RST   8'h00
`define PTPPS_PERIOD_RST  8'hff
`define PTPPS_CTRL_RST    7'h00
`define PTPPS_FLAG_RST    1'h0

// control field layout
`define PTPPS_CTRL_MSB    6
`define PTPPS_POST_MSB    6
`define PTPPS_POST_LSB    3
`define PTPPS_RUN_BIT     2
`define PTPPS_PRE_MSB     1
`define PTPPS_PRE_LSB     0
`define PTPPS_FLAG_BIT    1

// divider terminal values and prescale select codes
`define PTPPS_Q_LAST      2'h3
`define PTPPS_PRE_SEL1    2'h0
`define PTPPS_PRE_SEL4    2'h1
`define PTPPS_PRE_DIV1    4'h0
`define PTPPS_PRE_DIV4    4'h3
`define PTPPS_PRE_DIV16   4'hf

`endif

// ### ptpps_pkg.sv
package ptpps_pkg;
   typedef logic [7:0]  ptpps_byte_t;
   typedef logic [3:0]  ptpps_nib_t;
   typedef logic [6:0]  ptpps_ctrl_t;
   typedef logic [31:0] ptpps_word_t;
endpackage

// ### ptpps_ratio_cnt.sv
`timescale 1ns/1ps
`default_nettype none
module ptpps_ratio_cnt #(
   parameter int W = 4
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         ce,
   input  wire logic         clr,
   input  wire logic         step,
   input  wire logic [W-1:0] last,
   output wire logic         hit,
   output logic      [W-1:0] cnt_r
);
   logic [W-1:0] cnt_nxt;
   wire          at_last;

   assign at_last = (cnt_r == last);
   // clear beats a step so a cleared divider never reports a hit
   assign hit     = ce && step && !clr && at_last;
   assign cnt_nxt = at_last ? {W{1'b0}} : cnt_r + {{(W-1){1'b0}}, 1'b1};

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         cnt_r <= {W{1'b0}};
      else if (ce)
      begin
         if (clr)
            cnt_r <= {W{1'b0}};
         else if (step)
            cnt_r <= cnt_nxt;
      end
   end
endmodule
`default_nettype wire

// ### ptpps_apb_slv.sv
`timescale 1ns/1ps
`default_nettype none
module ptpps_apb_slv (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic        miss,
   input  wire logic [31:0] rd_val,
   output wire logic        pready,
   output logic      [31:0] prdata_r,
   output logic             pslverr_r,
   output wire logic        wr_stb
);
   logic armed_r;
   wire  setup;
   wire  done;

   // a frozen block stalls the bus rather than dropping a write
   // a frozen setup edge costs one wait state, so stale data never goes out
   assign pready = ce && armed_r;
   assign setup  = psel && ce && !armed_r;
   assign done   = psel && penable && ce && armed_r;
   assign wr_stb = done && pwrite && !pslverr_r;

   // read data caught once per transfer so the output is a flop
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         prdata_r  <= 32'h00000000;
         pslverr_r <= 1'b0;
         armed_r   <= 1'b0;
      end
      else if (setup)
      begin
         prdata_r  <= pwrite ? 32'h00000000 : rd_val;
         pslverr_r <= miss;
         armed_r   <= 1'b1;
      end
      else if (done)
         armed_r <= 1'b0;
   end
endmodule
`default_nettype wire

// ### ptpps_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ptpps_cfg.svh"
module ptpps_top (
   input  wire logic        CLK_SYS,
   input  wire logic        RST_N,
   input  wire logic        CE,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output wire logic        PREADY,
   output logic             PSLVERR,
   output logic      [7:0]  TIMER_COUNT,
   output logic             PERIOD_MATCH,
   output logic             MATCH_FLAG
);
   ptpps_pkg::ptpps_byte_t count_r;
   ptpps_pkg::ptpps_byte_t count_nxt;
   ptpps_pkg::ptpps_byte_t period_r;
   ptpps_pkg::ptpps_ctrl_t ctrl_r;
   ptpps_pkg::ptpps_nib_t  pre_last;
   ptpps_pkg::ptpps_nib_t  pre_cnt;
   ptpps_pkg::ptpps_nib_t  post_cnt;
   ptpps_pkg::ptpps_nib_t  post_sel;
   ptpps_pkg::ptpps_word_t rd_val;
   logic                   flag_r;
   logic                   flag_nxt;
   logic                   match_r;
   logic [1:0]             q_cnt;
   logic [1:0]             pre_sel;

   wire q_hit;
   wire pre_hit;
   wire post_hit;
   wire match_hit;
   wire at_period;
   wire run;
   wire psc_clr;
   wire wr_stb;
   wire sel_flag;
   wire sel_count;
   wire sel_ctrl;
   wire sel_period;
   wire miss;
   wire cnt_wr;
   wire ctl_wr;
   wire per_wr;
   wire flag_wr;

   // address decode
   assign sel_flag   = (PADDR == {`PTPPS_IDX_FLAG, `PTPPS_BYTE_LANE});
   assign sel_count  = (PADDR == {`PTPPS_IDX_COUNT, `PTPPS_BYTE_LANE});
   assign sel_ctrl   = (PADDR == {`PTPPS_IDX_CTRL, `PTPPS_BYTE_LANE});
   assign sel_period = (PADDR == {`PTPPS_IDX_PERIOD, `PTPPS_BYTE_LANE});
   assign miss       = !(sel_flag || sel_count || sel_ctrl || sel_period);

   assign cnt_wr  = wr_stb && sel_count;
   assign ctl_wr  = wr_stb && sel_ctrl;
   assign per_wr  = wr_stb && sel_period;
   assign flag_wr = wr_stb && sel_flag;

   // control fields
   assign run      = ctrl_r[`PTPPS_RUN_BIT];
   assign pre_sel  = ctrl_r[`PTPPS_PRE_MSB:`PTPPS_PRE_LSB];
   assign post_sel = ctrl_r[`PTPPS_POST_MSB:`PTPPS_POST_LSB];

   // read mux; unused upper bits and control bit 7 read zero
   assign rd_val = sel_count  ? {24'h000000, count_r} :
                   sel_period ? {24'h000000, period_r} :
                   sel_ctrl   ? {25'h0000000, ctrl_r} :
                   sel_flag   ? {30'h00000000, flag_r, 1'h0} :
                                32'h00000000;

   ptpps_apb_slv u_apb (
      .clk       (CLK_SYS),
      .rst_n     (RST_N),
      .ce        (CE),
      .psel      (PSEL),
      .penable   (PENABLE),
      .pwrite    (PWRITE),
      .miss      (miss),
      .rd_val    (rd_val),
      .pready    (PREADY),
      .prdata_r  (PRDATA),
      .pslverr_r (PSLVERR),
      .wr_stb    (wr_stb)
   );

   // instruction-rate tick from the system clock
   ptpps_ratio_cnt #(.W(2)) u_qdiv (
      .clk   (CLK_SYS),
      .rst_n (RST_N),
      .ce    (CE),
      .clr   (1'b0),
      .step  (1'b1),
      .last  (`PTPPS_Q_LAST),
      .hit   (q_hit),
      .cnt_r (q_cnt)
   );

   assign pre_last = (pre_sel == `PTPPS_PRE_SEL1) ? `PTPPS_PRE_DIV1 :
                     (pre_sel == `PTPPS_PRE_SEL4) ? `PTPPS_PRE_DIV4 :
                                                    `PTPPS_PRE_DIV16;

   // only count and control writes that land clear the dividers; a refused access does not
   assign psc_clr = cnt_wr || ctl_wr;

   ptpps_ratio_cnt #(.W(4)) u_pre (
      .clk   (CLK_SYS),
      .rst_n (RST_N),
      .ce    (CE),
      .clr   (psc_clr),
      .step  (q_hit && run),
      .last  (pre_last),
      .hit   (pre_hit),
      .cnt_r (pre_cnt)
   );

   assign at_period = (count_r == period_r);
   assign match_hit = pre_hit && at_period;
   assign count_nxt = at_period ? `PTPPS_COUNT_RST : count_r + 8'h01;

   ptpps_ratio_cnt #(.W(4)) u_post (
      .clk   (CLK_SYS),
      .rst_n (RST_N),
      .ce    (CE),
      .clr   (psc_clr),
      .step  (match_hit),
      .last  (post_sel),
      .hit   (post_hit),
      .cnt_r (post_cnt)
   );

   // hardware set wins over a software clear in the same cycle
   assign flag_nxt = post_hit || (flag_wr ? PWDATA[`PTPPS_FLAG_BIT] : flag_r);

   always_ff @(posedge CLK_SYS)
   begin
      if (!RST_N)
         count_r <= `PTPPS_COUNT_RST;
      else if (CE)
      begin
         if (cnt_wr)
            count_r <= PWDATA[7:0];
         else if (pre_hit)
            count_r <= count_nxt;
      end
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (!RST_N)
      begin
         period_r <= `PTPPS_PERIOD_RST;
         ctrl_r   <= `PTPPS_CTRL_RST;
      end
      else if (CE)
      begin
         if (per_wr)
            period_r <= PWDATA[7:0];
         if (ctl_wr)
            ctrl_r <= PWDATA[`PTPPS_CTRL_MSB:0];
      end
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (!RST_N)
      begin
         flag_r  <= `PTPPS_FLAG_RST;
         match_r <= 1'b0;
      end
      else if (CE)
      begin
         flag_r  <= flag_nxt;
         match_r <= match_hit;
      end
   end

   // count and match leave as flops for the serial port and pwm unit
   assign TIMER_COUNT  = count_r;
   assign PERIOD_MATCH = match_r;
   assign MATCH_FLAG   = flag_r;

   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RST_N);

   quarter_tick_a : assert property (
      q_hit |=> !q_hit
   ) else $error("instruction tick came twice in a row");

   pre_ratio_a : assert property (
      pre_hit |-> (q_hit && run && pre_cnt == pre_last)
   ) else $error("prescaler fired off its terminal value");

   pre_sel_a : assert property (
      (pre_hit && pre_sel[1]) |-> (pre_cnt == `PTPPS_PRE_DIV16)
   ) else $error("upper prescale bit did not give divide by sixteen");

   pre_one_a : assert property (
      (q_hit && run && !psc_clr && pre_sel == `PTPPS_PRE_SEL1) |-> pre_hit
   ) else $error("divide by one skipped a tick");

   count_wrap_a : assert property (
      (match_hit && !cnt_wr) |=> (count_r == `PTPPS_COUNT_RST)
   ) else $error("count did not wrap after the period match");

   count_step_a : assert property (
      (pre_hit && !at_period) |=> (count_r == $past(count_r) + 8'h01)
   ) else $error("count did not advance by one");

   flag_set_a : assert property (
      post_hit |=> MATCH_FLAG
   ) else $error("postscaler terminal did not set the flag");

   post_one_a : assert property (
      (match_hit && post_sel == 4'h0) |-> post_hit
   ) else $error("postscale 1:1 missed a match");

   post_ratio_a : assert property (
      post_hit |-> (post_cnt == post_sel)
   ) else $error("postscaler fired before its ratio");

   div_clear_a : assert property (
      psc_clr |=> (pre_cnt == 4'h0 && post_cnt == 4'h0)
   ) else $error("dividers not cleared by the write");

   ctl_keep_a : assert property (
      (ctl_wr && !cnt_wr) |=> (count_r == $past(count_r))
   ) else $error("control write disturbed the count");

   count_wr_a : assert property (
      cnt_wr |=> (count_r == $past(PWDATA[7:0]))
   ) else $error("count write not stored");

   period_wr_a : assert property (
      per_wr |=> (period_r == $past(PWDATA[7:0]))
   ) else $error("period write not stored");

   stop_hold_a : assert property (
      (!run && !cnt_wr) |=> (count_r == $past(count_r))
   ) else $error("count moved while the timer is off");

   ctrl_top_a : assert property (
      (PSEL && PENABLE && PREADY && !PWRITE && sel_ctrl) |-> (PRDATA[31:7] == 25'h0000000)
   ) else $error("absent control bits read nonzero");

   match_out_a : assert property (
      (match_hit ##1 CE) |-> (PERIOD_MATCH ##1 !PERIOD_MATCH)
   ) else $error("match pulse not offered for one cycle");

   flag_hold_a : assert property (
      (MATCH_FLAG && !flag_wr) |=> MATCH_FLAG
   ) else $error("flag dropped without a software clear");

   quarter_count_a : assert property (
      CE |=> (q_cnt == 2'($past(q_cnt) + 2'h1))
   ) else $error("instruction divider skipped a step");

   count_hold_a : assert property (
      (!pre_hit && !cnt_wr) |=> (count_r == $past(count_r))
   ) else $error("count moved without a prescaler tick");

   ctrl_wr_a : assert property (
      ctl_wr |=> (ctrl_r == $past(PWDATA[`PTPPS_CTRL_MSB:0]))
   ) else $error("control write not stored");

   period_keep_a : assert property (
      !per_wr |=> (period_r == $past(period_r))
   ) else $error("period changed without a write");

   freeze_hold_a : assert property (
      !CE |=> (count_r == $past(count_r) && pre_cnt == $past(pre_cnt) && flag_r == $past(flag_r))
   ) else $error("state moved while the clock enable was low");

   bus_err_a : assert property (
      (PSEL && PENABLE && PREADY) |-> (PSLVERR == miss)
   ) else $error("error response does not match the address");

   match_zero_a : assert property (
      PERIOD_MATCH |-> (TIMER_COUNT == `PTPPS_COUNT_RST)
   ) else $error("match pulse offered with a nonzero count");

   flag_wr_a : assert property (
      (flag_wr && !post_hit) |=> (MATCH_FLAG == $past(PWDATA[`PTPPS_FLAG_BIT]))
   ) else $error("software flag write not stored");
endmodule
`default_nettype wire

// ### ptpps_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "ptpps_cfg.svh"
module ptpps_bench;
   localparam logic [11:0] A_FLAG   = {`PTPPS_IDX_FLAG, 2'h0};
   localparam logic [11:0] A_COUNT  = {`PTPPS_IDX_COUNT, 2'h0};
   localparam logic [11:0] A_CTRL   = {`PTPPS_IDX_CTRL, 2'h0};
   localparam logic [11:0] A_PERIOD = {`PTPPS_IDX_PERIOD, 2'h0};
   logic                   clk_sys;
   logic                   rst_n;
   logic                   ce;
   logic                   psel;
   logic                   penable;
   logic                   pwrite;
   logic [11:0]            paddr;
   ptpps_pkg::ptpps_word_t pwdata;
   ptpps_pkg::ptpps_word_t prdata;
   ptpps_pkg::ptpps_word_t rd;
   ptpps_pkg::ptpps_byte_t timer_count;
   logic                   pready;
   logic                   pslverr;
   logic                   period_match;
   logic                   match_flag;
   logic                   er;
   int                     error_cnt;
   int                     total_checks;
   int                     n;
   int                     p;
   int                     ps_tab [4];

   ptpps_top i_dut (
      .CLK_SYS      (clk_sys),
      .RST_N        (rst_n),
      .CE           (ce),
      .PSEL         (psel),
      .PENABLE      (penable),
      .PWRITE       (pwrite),
      .PADDR        (paddr),
      .PWDATA       (pwdata),
      .PRDATA       (prdata),
      .PREADY       (pready),
      .PSLVERR      (pslverr),
      .TIMER_COUNT  (timer_count),
      .PERIOD_MATCH (period_match),
      .MATCH_FLAG   (match_flag)
   );

   initial clk_sys = 1'b0;
   always #2 clk_sys = ~clk_sys;

   task automatic check(input ptpps_pkg::ptpps_word_t got, input ptpps_pkg::ptpps_word_t exp);
      total_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // holds the whole request until pready is seen high at an edge
   task automatic apb(input logic w, input logic [11:0] a, input ptpps_pkg::ptpps_word_t d);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1)
         @(posedge clk_sys);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // cycles until the next match pulse, bounded so a dead timer cannot hang
   task automatic next_match(output int cyc);
      cyc = 0;
      do
      begin
         @(posedge clk_sys);
         cyc++;
      end
      while (period_match !== 1'b1 && cyc < 20000);
   endtask

   function automatic int per_cyc(input int ps, input int per);
      return 4 * (ps == 0 ? 1 : (ps == 1 ? 4 : 16)) * (per + 1);
   endfunction

   task automatic end_sim;
      $display("checks=%0d mismatches=%0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial
   begin
      #400000;
      error_cnt++;
      end_sim();
   end

   initial
   begin
      rst_n = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      error_cnt = 0;
      total_checks = 0;
      n = $urandom(7);
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      apb(1'b0, A_COUNT, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, A_CTRL, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, A_PERIOD, 32'h0);
      check(rd, 32'hff);
      apb(1'b1, 12'h04c, 32'h55);
      check({31'h0, er}, 32'h1);
      $display("reset values done");
      repeat (4)
      begin
         p = $urandom_range(0, 255);
         apb(1'b1, A_PERIOD, p);
         apb(1'b0, A_PERIOD, 32'h0);
         check(rd, p);
      end
      apb(1'b1, A_CTRL, 32'hfb);
      apb(1'b0, A_CTRL, 32'h0);
      check(rd, 32'h7b);
      p = $urandom_range(0, 255);
      apb(1'b1, A_COUNT, p);
      apb(1'b1, A_CTRL, 32'h78);
      repeat (40) @(posedge clk_sys);
      apb(1'b0, A_COUNT, 32'h0);
      check(rd, p);
      check(timer_count, p);
      $display("register access done");
      for (int k = 0; k < 4; k++)
      begin
         p = $urandom_range(1, 12);
         apb(1'b1, A_COUNT, 32'h0);
         apb(1'b1, A_PERIOD, p);
         apb(1'b1, A_CTRL, k | 4);
         next_match(n);
         next_match(n);
         check(n, per_cyc(k, p));
         check(timer_count, 32'h0);
         @(posedge clk_sys);
         check(period_match, 32'h0);
      end
      $display("prescaler done");
      ps_tab = '{0, 1, 0, 15};
      ps_tab[2] = $urandom_range(2, 14);
      foreach (ps_tab[i])
      begin
         apb(1'b1, A_CTRL, 32'h0);
         apb(1'b1, A_FLAG, 32'h0);
         apb(1'b1, A_COUNT, 32'h0);
         apb(1'b1, A_PERIOD, 32'h2);
         apb(1'b1, A_CTRL, (ps_tab[i] << 3) | 4);
         n = 0;
         for (int c = 0; c < 2000 && match_flag !== 1'b1; c++)
         begin
            @(posedge clk_sys);
            if (period_match === 1'b1)
               n++;
         end
         check(n, ps_tab[i] + 1);
         repeat (30) @(posedge clk_sys);
         apb(1'b1, A_CTRL, 32'h0);
         apb(1'b0, A_FLAG, 32'h0);
         check(rd, 32'h2);
         apb(1'b1, A_FLAG, 32'h0);
         apb(1'b0, A_FLAG, 32'h0);
         check(rd, 32'h0);
      end
      $display("postscaler done");
      apb(1'b1, A_FLAG, 32'h2);
      apb(1'b0, A_FLAG, 32'h0);
      check(rd, 32'h2);
      apb(1'b1, A_PERIOD, 32'hff);
      apb(1'b1, A_CTRL, 32'h06);
      repeat (50) @(posedge clk_sys);
      apb(1'b1, A_COUNT, 32'h10);
      // the divide-by-four phase survives the write, hence the window
      repeat (60) @(posedge clk_sys);
      check(timer_count, 32'h10);
      repeat (8) @(posedge clk_sys);
      check(timer_count, 32'h11);
      $display("prescaler clear done");
      rst_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      apb(1'b0, A_COUNT, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, A_PERIOD, 32'h0);
      check(rd, 32'hff);
      apb(1'b0, A_CTRL, 32'h0);
      check(rd, 32'h0);
      $display("mid-run reset done");
      apb(1'b1, A_CTRL, 32'h0);
      // first pass freezes the setup edge, second the access phase
      for (int d = 1; d < 3; d++)
      begin
         p = $urandom_range(0, 255);
         apb(1'b1, A_COUNT, p);
         fork
            apb(1'b0, A_COUNT, 32'h0);
            begin
               repeat (d) @(posedge clk_sys);
               ce <= 1'b0;
               repeat (5) @(posedge clk_sys);
               check(pready, 32'h0);
               ce <= 1'b1;
            end
         join
         check(rd, p);
      end
      $display("stalled read done");
      end_sim();
   end
endmodule
`default_nettype wire
